// ---- rtl/eari_regs.v ----
/*
  Register layer of an eSPI agent: local memory-mapped status, control,
  error and FIFO windows, plus the host-visible status word.
  Assumes the serial framing engine runs on the link clock and presents
  put/get bytes, error events and virtual-wire state on the link pins,
  stable around each rising edge of link_clk. All link pins, the link
  clock and the eSPI reset are sampled by sys_clk through two flip-flops.
*/
`timescale 1ns/100ps
`include "eari_defines.vh"

//
// Behaviour
// - Status 0x0 read, control 0x4, errors 0x18
// - Byte FIFO windows at 0x8,0xC,0x10,0x14
// - Host puts fill posted/non-posted receive FIFOs
// - Status bit0: posted receive FIFO not empty
// - Status bit1: non-posted receive FIFO not empty
// - Control bit0 marks posted packet loaded
// - Control bit1 marks non-posted packet loaded
// - Error flags sticky until written one
// - Errors 0-3: opcode, cycle, CRC, chip-select
// - Errors 4-7: put, get, malformed packets
// - Host status readable locally at 00h
// - Status field returned every transaction
// - Status updates only at chip-select deassertion or eSPI reset
// - Host status read-only, cleared by eSPI reset
// - Host bit0: posted receive FIFO empty
// - Host bit1: non-posted receive FIFO empty
// - Host bit4: posted packet waits to send
// - Host bit5: non-posted packet waits to send
// - Host bit6: virtual wire pending
// - Host bits 2,3,8,9 tied one
// - Host bits 7,12,13 tied zero
module eari_regs #(
  parameter FIFO_DEPTH = `EARI_FIFO_DEPTH,
  parameter FIFO_AW = `EARI_FIFO_AW
) (
  input wire sys_clk,
  input wire srst,
  input wire [`EARI_ADDR_W-1:0] bus_address,
  input wire bus_read,
  input wire bus_write,
  input wire [31:0] bus_writedata,
  output reg [31:0] bus_readdata,
  output reg bus_readvalid,
  input wire link_clk,
  input wire link_cs_n,
  input wire link_reset_n,
  input wire link_put_valid,
  input wire link_put_np,
  input wire [7:0] link_put_data,
  output wire link_put_ready,
  input wire link_get_req,
  input wire link_get_np,
  output reg [7:0] link_get_data,
  output reg link_get_valid,
  input wire [`EARI_ERR_W-1:0] link_err_event,
  input wire link_vw_pending,
  output wire [`EARI_HSTAT_W-1:0] link_status
);
  localparam SYNC_W = 24;

  // Two-stage sampling of everything that comes off the link
  reg [SYNC_W-1:0] sync_a;
  reg [SYNC_W-1:0] sync_b;
  reg link_clk_d;
  reg cs_n_d;
  wire [SYNC_W-1:0] link_pins;
  wire link_clk_s;
  wire cs_n_s;
  wire reset_n_s;
  wire put_valid_s;
  wire put_np_s;
  wire [7:0] put_data_s;
  wire get_req_s;
  wire get_np_s;
  wire [`EARI_ERR_W-1:0] err_s;
  wire vw_pending_s;
  wire link_edge;
  wire cs_release;

  assign link_pins = {link_clk, link_cs_n, link_reset_n, link_put_valid, link_put_np,
                      link_put_data, link_get_req, link_get_np, link_err_event, link_vw_pending};
  assign {link_clk_s, cs_n_s, reset_n_s, put_valid_s, put_np_s, put_data_s, get_req_s,
          get_np_s, err_s, vw_pending_s} = sync_b;

  // Data pins share the clock's delay, so they are sampled mid-bit
  always @(posedge sys_clk) begin
    if (srst) begin
      sync_a <= {1'b0, 1'b1, 1'b1, {(SYNC_W-3){1'b0}}};
      sync_b <= {1'b0, 1'b1, 1'b1, {(SYNC_W-3){1'b0}}};
      link_clk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sync_a <= link_pins;
      sync_b <= sync_a;
      link_clk_d <= link_clk_s;
      cs_n_d <= cs_n_s;
    end
  end

  assign link_edge = link_clk_s & ~link_clk_d & ~cs_n_s;
  assign cs_release = cs_n_s & ~cs_n_d;

  // Bus decode
  wire rd_status;
  wire rd_pc_rx;
  wire rd_np_rx;
  wire rd_error;
  wire wr_control;
  wire wr_pc_tx;
  wire wr_np_tx;
  wire wr_error;

  assign rd_status = bus_read & (bus_address == `EARI_OFS_STATUS);
  assign rd_pc_rx = bus_read & (bus_address == `EARI_OFS_PC_RX);
  assign rd_np_rx = bus_read & (bus_address == `EARI_OFS_NP_RX);
  assign rd_error = bus_read & (bus_address == `EARI_OFS_ERROR);
  assign wr_control = bus_write & (bus_address == `EARI_OFS_CONTROL);
  assign wr_pc_tx = bus_write & (bus_address == `EARI_OFS_PC_TX);
  assign wr_np_tx = bus_write & (bus_address == `EARI_OFS_NP_TX);
  assign wr_error = bus_write & (bus_address == `EARI_OFS_ERROR);

  // Put path: two-entry buffer absorbs a stall while a FIFO is full
  wire put_take;
  wire skid_in_ready;
  wire skid_valid;
  wire [8:0] skid_data;
  wire skid_ready;
  wire pc_rx_in_ready;
  wire np_rx_in_ready;

  assign put_take = link_edge & put_valid_s;
  assign link_put_ready = skid_in_ready;
  assign skid_ready = skid_data[8] ? np_rx_in_ready : pc_rx_in_ready;

  eari_fifo #(
    .WIDTH(9),
    .DEPTH(`EARI_SKID_DEPTH),
    .AW(`EARI_SKID_AW)
  ) u_put_skid (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(put_take),
    .in_data({put_np_s, put_data_s}),
    .in_ready(skid_in_ready),
    .out_valid(skid_valid),
    .out_data(skid_data),
    .out_ready(skid_ready),
    .level()
  );

  wire pc_rx_valid;
  wire [7:0] pc_rx_data;
  wire [FIFO_AW:0] pc_rx_level;
  wire np_rx_valid;
  wire [7:0] np_rx_data;
  wire [FIFO_AW:0] np_rx_level;

  eari_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_pc_rx (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(skid_valid & ~skid_data[8]),
    .in_data(skid_data[7:0]),
    .in_ready(pc_rx_in_ready),
    .out_valid(pc_rx_valid),
    .out_data(pc_rx_data),
    .out_ready(rd_pc_rx),
    .level(pc_rx_level)
  );

  eari_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_np_rx (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(skid_valid & skid_data[8]),
    .in_data(skid_data[7:0]),
    .in_ready(np_rx_in_ready),
    .out_valid(np_rx_valid),
    .out_data(np_rx_data),
    .out_ready(rd_np_rx),
    .level(np_rx_level)
  );

  // Transmit path: software fills, host gets drain
  wire get_take;
  wire pc_get;
  wire np_get;
  wire pc_tx_valid;
  wire [7:0] pc_tx_data;
  wire [FIFO_AW:0] pc_tx_level;
  wire np_tx_valid;
  wire [7:0] np_tx_data;
  wire [FIFO_AW:0] np_tx_level;

  assign get_take = link_edge & get_req_s;
  assign pc_get = get_take & ~get_np_s;
  assign np_get = get_take & get_np_s;

  // Writes to a full transmit FIFO are dropped; software sizes packets
  eari_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_pc_tx (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(wr_pc_tx),
    .in_data(bus_writedata[7:0]),
    .in_ready(),
    .out_valid(pc_tx_valid),
    .out_data(pc_tx_data),
    .out_ready(pc_get),
    .level(pc_tx_level)
  );

  eari_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_np_tx (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(wr_np_tx),
    .in_data(bus_writedata[7:0]),
    .in_ready(),
    .out_valid(np_tx_valid),
    .out_data(np_tx_data),
    .out_ready(np_get),
    .level(np_tx_level)
  );

  always @(posedge sys_clk) begin
    if (srst) begin
      link_get_data <= 8'h00;
      link_get_valid <= 1'b0;
    end else begin
      link_get_valid <= (pc_get & pc_tx_valid) | (np_get & np_tx_valid);
      if (pc_get & pc_tx_valid) begin
        link_get_data <= pc_tx_data;
      end else if (np_get & np_tx_valid) begin
        link_get_data <= np_tx_data;
      end
    end
  end

  // Control: software sets, hardware clears once the packet is gone
  reg posted_tx_loaded;
  reg nonposted_tx_loaded;
  wire pc_drained;
  wire np_drained;
  wire [FIFO_AW:0] one_byte;

  assign one_byte = {{FIFO_AW{1'b0}}, 1'b1};
  assign pc_drained = pc_get & (pc_tx_level == one_byte);
  assign np_drained = np_get & (np_tx_level == one_byte);

  always @(posedge sys_clk) begin
    if (srst) begin
      posted_tx_loaded <= 1'b0;
      nonposted_tx_loaded <= 1'b0;
    end else begin
      // Set wins over a same-cycle drain
      if (wr_control & bus_writedata[`EARI_CTRL_PC_TX_LOADED]) begin
        posted_tx_loaded <= 1'b1;
      end else if (pc_drained) begin
        posted_tx_loaded <= 1'b0;
      end
      if (wr_control & bus_writedata[`EARI_CTRL_NP_TX_LOADED]) begin
        nonposted_tx_loaded <= 1'b1;
      end else if (np_drained) begin
        nonposted_tx_loaded <= 1'b0;
      end
    end
  end

  // Error flags
  reg [`EARI_ERR_W-1:0] error_flags;
  wire [`EARI_ERR_W-1:0] err_set;
  wire [`EARI_ERR_W-1:0] err_clr;
  wire [`EARI_ERR_W-1:0] next_error_flags;

  assign err_set[`EARI_ERR_BAD_OPCODE] = link_edge & err_s[`EARI_ERR_BAD_OPCODE];
  assign err_set[`EARI_ERR_BAD_CYCLE] = link_edge & err_s[`EARI_ERR_BAD_CYCLE];
  assign err_set[`EARI_ERR_CMD_CRC] = link_edge & err_s[`EARI_ERR_CMD_CRC];
  // Chip-select drop is reported when no further link edge may come
  assign err_set[`EARI_ERR_CS_DROP] = cs_release & err_s[`EARI_ERR_CS_DROP];
  assign err_set[`EARI_ERR_PUT_NO_FREE] = put_take & ~skid_in_ready;
  assign err_set[`EARI_ERR_GET_NO_AVAIL] = (pc_get & ~pc_tx_valid) | (np_get & ~np_tx_valid);
  assign err_set[`EARI_ERR_PC_MALFORMED] = link_edge & err_s[`EARI_ERR_PC_MALFORMED];
  assign err_set[`EARI_ERR_VW_MALFORMED] = link_edge & err_s[`EARI_ERR_VW_MALFORMED];
  assign err_clr = wr_error ? bus_writedata[`EARI_ERR_W-1:0] : {`EARI_ERR_W{1'b0}};
  assign next_error_flags = (error_flags & ~err_clr) | err_set;

  always @(posedge sys_clk) begin
    if (srst) begin
      error_flags <= `EARI_ERR_RESET;
    end else begin
      error_flags <= next_error_flags;
    end
  end

  // Host-visible status, latched at chip-select release
  reg [`EARI_HSTAT_W-1:0] host_visible_status;
  reg [`EARI_HSTAT_W-1:0] next_host_status;

  always @* begin
    next_host_status = `EARI_HSTAT_RESET;
    next_host_status[`EARI_HSTAT_PC_SPACE] = ~pc_rx_valid;
    next_host_status[`EARI_HSTAT_NP_SPACE] = ~np_rx_valid;
    next_host_status[`EARI_HSTAT_PC_PENDING] = posted_tx_loaded;
    next_host_status[`EARI_HSTAT_NP_PENDING] = nonposted_tx_loaded;
    next_host_status[`EARI_HSTAT_VW_PENDING] = vw_pending_s;
  end

  always @(posedge sys_clk) begin
    if (srst | ~reset_n_s) begin
      host_visible_status <= `EARI_HSTAT_RESET;
    end else if (cs_release) begin
      host_visible_status <= next_host_status;
    end
  end

  // Constant ones are ORed in outside the register; tied zeros stay 0 inside it
  assign link_status = host_visible_status | `EARI_HSTAT_TIE_ONE;

  // Read data, one cycle after the request
  reg [31:0] next_readdata;

  always @* begin
    next_readdata = 32'h00000000;
    if (rd_status) begin
      next_readdata[`EARI_STAT_PC_RX_READY] = pc_rx_valid;
      next_readdata[`EARI_STAT_NP_RX_READY] = np_rx_valid;
      next_readdata[`EARI_STAT_HOST_LSB+`EARI_HSTAT_W-1:`EARI_STAT_HOST_LSB] = link_status;
    end else if (rd_pc_rx) begin
      next_readdata[7:0] = pc_rx_valid ? pc_rx_data : 8'h00;
    end else if (rd_np_rx) begin
      next_readdata[7:0] = np_rx_valid ? np_rx_data : 8'h00;
    end else if (rd_error) begin
      next_readdata[`EARI_ERR_W-1:0] = error_flags;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      bus_readdata <= 32'h00000000;
      bus_readvalid <= 1'b0;
    end else begin
      bus_readdata <= next_readdata;
      bus_readvalid <= bus_read;
    end
  end

  // Levels kept for visibility of fill depth; only emptiness is reported
  wire unused_levels;
  assign unused_levels = ^{pc_rx_level, np_rx_level};
endmodule // eari_regs

// ---- rtl/eari_defines.vh ----
/*
  Constants of the eSPI agent register interface: local bus offsets,
  field positions, reset values and the host-visible status layout.
  Assumes inclusion by bare name from the design files.
*/
`ifndef EARI_DEFINES_VH
`define EARI_DEFINES_VH

`define EARI_ADDR_W 5
`define EARI_OFS_STATUS 5'h00
`define EARI_OFS_CONTROL 5'h04
`define EARI_OFS_PC_RX 5'h08
`define EARI_OFS_PC_TX 5'h0C
`define EARI_OFS_NP_RX 5'h10
`define EARI_OFS_NP_TX 5'h14
`define EARI_OFS_ERROR 5'h18

`define EARI_STAT_PC_RX_READY 0
`define EARI_STAT_NP_RX_READY 1
`define EARI_STAT_HOST_LSB 16

`define EARI_CTRL_PC_TX_LOADED 0
`define EARI_CTRL_NP_TX_LOADED 1

`define EARI_ERR_W 8
`define EARI_ERR_BAD_OPCODE 0
`define EARI_ERR_BAD_CYCLE 1
`define EARI_ERR_CMD_CRC 2
`define EARI_ERR_CS_DROP 3
`define EARI_ERR_PUT_NO_FREE 4
`define EARI_ERR_GET_NO_AVAIL 5
`define EARI_ERR_PC_MALFORMED 6
`define EARI_ERR_VW_MALFORMED 7
`define EARI_ERR_FROM_LINK 8'hCF
`define EARI_ERR_RESET 8'h00

`define EARI_HSTAT_W 16
`define EARI_HSTAT_PC_SPACE 0
`define EARI_HSTAT_NP_SPACE 1
`define EARI_HSTAT_PC_PENDING 4
`define EARI_HSTAT_NP_PENDING 5
`define EARI_HSTAT_VW_PENDING 6
`define EARI_HSTAT_TIE_ONE 16'h030C
`define EARI_HSTAT_RESET 16'h0000

`define EARI_FIFO_DEPTH 128
`define EARI_FIFO_AW 7
`define EARI_SKID_DEPTH 2
`define EARI_SKID_AW 1

`endif

// ---- rtl/eari_fifo.v ----
/*
  Synchronous first-word-fall-through FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-high reset, DEPTH <= 2**AW.
*/
`timescale 1ns/100ps
module eari_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire sys_clk,
  input wire srst,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready,
  output wire [AW:0] level
);
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [AW-1:0] LAST = DEPTH_W[AW-1:0] - 1'b1;
  localparam [AW:0] FULL = DEPTH_W[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign level = count;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // eari_fifo

// ---- verification/eari_regs_chk.sv ----
/* Port checker for eari_regs, bound to every instance.
   Assumes one sys_clk domain reset by srst. */
`timescale 1ns/100ps
module eari_regs_chk (
  input wire sys_clk,
  input wire srst,
  input wire [4:0] bus_address,
  input wire bus_read,
  input wire [31:0] bus_readdata,
  input wire bus_readvalid,
  input wire link_cs_n,
  input wire link_reset_n,
  input wire link_put_ready,
  input wire [15:0] link_status
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // Six cycles outlast the two-flop delay of any earlier release
  sequence cs_held;
    (!link_cs_n && link_reset_n) [*6];
  endsequence
  sequence stat_rd;
    bus_read && bus_address == 5'h00;
  endsequence
  rd_answer_a: assert property (bus_read |=> bus_readvalid)
    else $error("read not answered");
  rd_lone_a: assert property (!bus_read |=> !bus_readvalid)
    else $error("read answer without request");
  hole_zero_a: assert property (bus_read && !(bus_address inside {5'h00, 5'h08, 5'h10, 5'h18})
    |=> bus_readdata == 32'h0) else $error("unreadable place not zero");
  win_upper_a: assert property (bus_read && (bus_address == 5'h08 || bus_address == 5'h10)
    |=> bus_readdata[31:8] == 24'h0) else $error("window upper bits set");
  stat_resv_a: assert property (stat_rd |=> bus_readdata[15:2] == 14'h0)
    else $error("status reserved bits set");
  stat_mirror_a: assert property (stat_rd |=> bus_readdata[31:16] == $past(link_status))
    else $error("host status not mirrored");
  tie_bits_a: assert property (link_status[3:2] == 2'h3 && link_status[9:8] == 2'h3
    && !link_status[7] && link_status[13:12] == 2'h0) else $error("tied bits wrong");
  frame_hold_a: assert property (cs_held |=> $stable(link_status))
    else $error("host status moved inside frame");
  host_clear_a: assert property ((!link_reset_n) [*5] |-> link_status == 16'h030C)
    else $error("link reset did not clear");
  rst_vals_a: assert property ($fell(srst) |-> link_status == 16'h030C && !bus_readvalid
    && link_put_ready) else $error("reset values wrong");
endmodule // eari_regs_chk

bind eari_regs eari_regs_chk eari_regs_chk_i (.sys_clk, .srst, .bus_address, .bus_read, .bus_readdata,
  .bus_readvalid, .link_cs_n, .link_reset_n, .link_put_ready, .link_status);

// ---- verification/eari_host_model.sv ----
/* Behavioural host framing engine driving the link pins.
   Assumes the bench calls one task at a time. */
`timescale 1ns/100ps
module eari_host_model (
  output logic link_clk,
  output logic link_cs_n,
  output logic link_reset_n,
  output logic link_put_valid,
  output logic link_put_np,
  output logic [7:0] link_put_data,
  output logic link_get_req,
  output logic link_get_np,
  output logic [7:0] link_err_event,
  output logic link_vw_pending
);
  initial begin
    link_clk = 0;
    link_cs_n = 1;
    link_reset_n = 1;
    link_put_valid = 0;
    link_put_np = 0;
    link_put_data = 8'h00;
    link_get_req = 0;
    link_get_np = 0;
    link_err_event = 8'h00;
    link_vw_pending = 0;
  end
  task set_side(input logic vw, input logic rn);
    link_vw_pending = vw;
    link_reset_n = rn;
  endtask
  task frame_open;
    link_cs_n = 0;
    #100;
  endtask
  // Clock only runs inside a frame
  task beat(input logic pv, input logic np, input logic [7:0] pd, input logic gr, input logic [7:0] ev);
    link_put_valid = pv;
    link_put_np = np;
    link_get_np = np;
    link_put_data = pd;
    link_get_req = gr;
    link_err_event = ev;
    #100 link_clk = 1;
    #100 link_clk = 0;
  endtask
  // Strobes hold between beats; the clock stays low, so no edge takes them
  task frame_close(input logic [7:0] ev);
    #100;
    link_put_valid = 0;
    link_get_req = 0;
    // Released data must not look valid
    link_put_data = ~link_put_data;
    link_err_event = ev;
    link_cs_n = 1;
    #400;
    link_err_event = 8'h00;
  endtask
  task blank;
    frame_open;
    frame_close(8'h00);
  endtask
endmodule // eari_host_model

// ---- verification/eari_regs_tb_top.sv ----
/* Self-checking bench for eari_regs with a host model on the link.
   Assumes 40 MHz sys_clk; FIFOs shrunk to eight bytes. */
`timescale 1ns/100ps
module eari_regs_tb_top;
  logic sys_clk, srst, bus_read, bus_write, bus_readvalid, link_put_ready, link_get_valid;
  logic [4:0] bus_address;
  logic [31:0] bus_writedata, bus_readdata, exp;
  logic [7:0] link_get_data;
  logic [15:0] link_status;
  wire link_clk, link_cs_n, link_reset_n, link_put_valid, link_put_np, link_get_req, link_get_np, link_vw_pending;
  wire [7:0] link_put_data, link_err_event;
  logic [7:0] got_q[$];
  int errors, compares, i;
  eari_regs #(.FIFO_DEPTH(8), .FIFO_AW(3)) eari_regs_i (.sys_clk, .srst, .bus_address, .bus_read, .bus_write,
    .bus_writedata, .bus_readdata, .bus_readvalid, .link_clk, .link_cs_n, .link_reset_n, .link_put_valid,
    .link_put_np, .link_put_data, .link_put_ready, .link_get_req, .link_get_np, .link_get_data,
    .link_get_valid, .link_err_event, .link_vw_pending, .link_status);
  eari_host_model eari_host_model_i (.link_clk, .link_cs_n, .link_reset_n, .link_put_valid, .link_put_np,
    .link_put_data, .link_get_req, .link_get_np, .link_err_event, .link_vw_pending);
  always @(posedge sys_clk) if (link_get_valid === 1'b1) got_q.push_back(link_get_data);
  task chk(input string what, input logic [31:0] want, input logic [31:0] seen);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task tick;
    @(posedge sys_clk);
    #2;
  endtask
  // Idle cycle after each access keeps strobes single-assigned
  task wr(input logic [4:0] a, input logic [31:0] d);
    bus_address = a;
    bus_writedata = d;
    bus_write = 1;
    tick;
    bus_write = 0;
    tick;
  endtask
  task rd(input logic [4:0] a, input logic [31:0] want, input string what);
    bus_address = a;
    bus_read = 1;
    tick;
    bus_read = 0;
    chk(what, want, bus_readvalid === 1'b1 ? bus_readdata : ~want);
    tick;
  endtask
  task close_out;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task t_reset;
    chk("host reset", 32'h030C, {16'h0, link_status});
    wr(5'h00, 32'hFFFFFFFF);
    wr(5'h08, 32'h55);
    rd(5'h00, 32'h030C0000, "status");
    rd(5'h04, 32'h0, "control");
    rd(5'h18, 32'h0, "errors");
    rd(5'h1C, 32'h0, "hole");
    rd(5'h08, 32'h0, "rx window");
  endtask
  task t_put;
    eari_host_model_i.frame_open;
    eari_host_model_i.beat(1, 0, 8'hA1, 0, 8'h00);
    eari_host_model_i.beat(1, 1, 8'hB1, 0, 8'h00);
    eari_host_model_i.beat(1, 0, 8'hA2, 0, 8'h00);
    eari_host_model_i.frame_close(8'h00);
    rd(5'h00, 32'h030C0003, "rx ready");
    rd(5'h08, 32'hA1, "posted rx");
    rd(5'h08, 32'hA2, "posted rx");
    rd(5'h10, 32'hB1, "np rx");
    rd(5'h00, 32'h030C0000, "held status");
    eari_host_model_i.blank;
    rd(5'h00, 32'h030F0000, "free status");
  endtask
  task t_tx;
    wr(5'h0C, 32'h5A5A5AC1);
    wr(5'h0C, 32'h000000C2);
    wr(5'h14, 32'h000000D1);
    wr(5'h04, 32'h00000003);
    chk("early status", 32'h030F, {16'h0, link_status});
    eari_host_model_i.blank;
    chk("tx pending", 32'h033F, {16'h0, link_status});
    got_q.delete();
    eari_host_model_i.frame_open;
    eari_host_model_i.beat(0, 0, 8'h00, 1, 8'h00);
    eari_host_model_i.beat(0, 0, 8'h00, 1, 8'h00);
    eari_host_model_i.beat(0, 1, 8'h00, 1, 8'h00);
    eari_host_model_i.frame_close(8'h00);
    chk("gets", 32'hC1C2D1, {8'h0, got_q[0], got_q[1], got_q[2]});
    chk("tx sent", 32'h030F, {16'h0, link_status});
  endtask
  task t_err;
    logic [7:0] ev [5] = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h80};
    eari_host_model_i.frame_open;
    // Ten bytes fit: eight in the FIFO, two in the buffer
    for (i = 0; i < 11; i++) eari_host_model_i.beat(1, 0, 8'h20 + i[7:0], 0, 8'h00);
    repeat (3) tick;
    chk("put ready", 32'h0, {31'h0, link_put_ready});
    rd(5'h18, 32'h10, "overflow");
    exp = 32'h10;
    foreach (ev[k]) begin
      eari_host_model_i.beat(0, 0, 8'h00, 0, ev[k]);
      repeat (3) tick;
      exp = exp | {24'h0, ev[k]};
      rd(5'h18, exp, "event");
    end
    eari_host_model_i.beat(0, 1, 8'h00, 1, 8'h00);
    eari_host_model_i.frame_close(8'h08);
    rd(5'h18, 32'hFF, "all errors");
    chk("rx full", 32'h030E, {16'h0, link_status});
    wr(5'h18, 32'h0F);
    rd(5'h18, 32'hF0, "clear low");
    wr(5'h18, 32'h00);
    rd(5'h18, 32'hF0, "zero kept");
    wr(5'h18, 32'hFFFFFFF0);
    rd(5'h18, 32'h00, "clear all");
    for (i = 0; i < 10; i++) rd(5'h08, 32'h20 + i, "drain");
    rd(5'h08, 32'h0, "drained");
  endtask
  task t_side;
    eari_host_model_i.set_side(1, 1);
    eari_host_model_i.blank;
    chk("vw pending", 32'h034F, {16'h0, link_status});
    eari_host_model_i.set_side(1, 0);
    repeat (6) tick;
    chk("link reset", 32'h030C, {16'h0, link_status});
    eari_host_model_i.set_side(0, 1);
    srst = 1;
    repeat (3) tick;
    srst = 0;
    t_reset;
  endtask
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    srst = 1;
    bus_read = 0;
    bus_write = 0;
    bus_address = 5'h00;
    bus_writedata = 32'h0;
    repeat (20) @(posedge sys_clk);
    #2;
    srst = 0;
    t_reset;
    t_put;
    t_tx;
    t_err;
    t_side;
    close_out;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    close_out;
  end
endmodule // eari_regs_tb_top
